// ### logic/fps_consts.vh
// constants shared by the flash program/erase sequencer files
// ==========================================================
// How it works
// - three unlock writes enable program and erase
// - mode 81h plus command 02h clears buffer
// - mode 89h loads buffer, address steps by two
// - mode A1h selects page programming
// - command 0Bh starts the page operation
// - mode 91h selects erase, same start command
// - erase ignores page buffer content
// - command 8Bh starts bulk erase, no address
// - mode 8Dh bulk erase also clears OTP
// - reads need no unlock or mode setup
`ifndef FPS_CONSTS_VH
`define FPS_CONSTS_VH

// ==========================================================
// unlock sequence
`define FPS_UNLOCK_ADDR_A 16'hF555
`define FPS_UNLOCK_ADDR_B 16'hFAAA
`define FPS_UNLOCK_DATA_1 8'hAA
`define FPS_UNLOCK_DATA_2 8'h55
`define FPS_UNLOCK_DATA_3 8'hA5

// ==========================================================
// flash mode register values
`define FPS_MODE_BUF_RESET 8'h81
`define FPS_MODE_BUF_SELECT 8'h89
`define FPS_MODE_PROGRAM 8'hA1
`define FPS_MODE_ERASE 8'h91
`define FPS_MODE_ERASE_OTP 8'h8D
`define FPS_MODE_RESET_VAL 8'h00

// ==========================================================
// flash command register values
`define FPS_CMD_BUF_CLEAR 8'h02
`define FPS_CMD_START 8'h0B
`define FPS_CMD_BULK 8'h8B
`define FPS_CMD_RESET_VAL 8'h00

// ==========================================================
// register selects on the register write/read port
`define FPS_SEL_MODE 3'h0
`define FPS_SEL_CMD 3'h1
`define FPS_SEL_ADDR_HIGH 3'h2
`define FPS_SEL_ADDR_MID 3'h3
`define FPS_SEL_ADDR_LOW 3'h4
`define FPS_SEL_TIMING 3'h5
`define FPS_SEL_STATUS 3'h6

// ==========================================================
// status register fields and reset values
`define FPS_STAT_READY_BIT 0
`define FPS_STAT_UNLOCK_BIT 1
`define FPS_STAT_CLEAR_BIT 2
`define FPS_TIMING_RESET_VAL 8'h00

// ==========================================================
// page buffer layout
`define FPS_BUF_BYTES 128
`define FPS_BUF_AW 7
`define FPS_BUF_STEP 7'h02
`define FPS_BUF_FILL 8'hFF
`define FPS_BUF_LAST 7'h7F

// ==========================================================
// timing: one timing unit per timing-register count
`define FPS_CLK_PERIOD_NS 10
`define FPS_TIME_UNIT_NS 1000
`define FPS_UNIT_CYCLES (`FPS_TIME_UNIT_NS / `FPS_CLK_PERIOD_NS)
// last count of the unit counter, sized to match it (unit cycles minus one)
`define FPS_UNIT_LAST 8'h63

// ==========================================================
// operation codes toward the flash array
`define FPS_OP_NONE 2'h0
`define FPS_OP_PROGRAM 2'h1
`define FPS_OP_PAGE_ERASE 2'h2
`define FPS_OP_BULK_ERASE 2'h3

`endif

// ### logic/fps_unlock.v
// unlock sequence checker for the flash program/erase sequencer
`timescale 1ns/10ps
`default_nettype none
`include "fps_consts.vh"

module fps_unlock (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // observed flash-space writes
  input wire wr,
  input wire [15:0] addr,
  input wire [7:0] data,
  // relock request, e.g. debug mode dropped
  input wire relock,
  // result
  output reg unlocked
);

  // ==========================================================
  // sequence position
  reg [1:0] step; // number of correct writes seen so far

  wire hit_1 = (addr == `FPS_UNLOCK_ADDR_A) && (data == `FPS_UNLOCK_DATA_1);
  wire hit_2 = (addr == `FPS_UNLOCK_ADDR_B) && (data == `FPS_UNLOCK_DATA_2);
  wire hit_3 = (addr == `FPS_UNLOCK_ADDR_A) && (data == `FPS_UNLOCK_DATA_3);

  // ==========================================================
  // step through the three writes; once unlocked, further writes are data
  always @(posedge clock) begin
    if (sys_rst || relock) begin
      step <= 2'h0;
      unlocked <= 1'b0;
    end else if (wr && !unlocked) begin
      case (step)
        2'h0: step <= hit_1 ? 2'h1 : 2'h0;
        2'h1: begin
          // a wrong write restarts, but may itself be a fresh first write
          if (hit_2) step <= 2'h2;
          else step <= hit_1 ? 2'h1 : 2'h0;
        end
        2'h2: begin
          if (hit_3) begin
            unlocked <= 1'b1;
            step <= 2'h0;
          end else begin
            step <= hit_1 ? 2'h1 : 2'h0;
          end
        end
        default: step <= 2'h0;
      endcase
    end
  end

endmodule // fps_unlock

`default_nettype wire

// ### logic/fps_sequencer.v
// flash program/erase sequencer: control registers, page buffer, operation timing
`timescale 1ns/10ps
`default_nettype none
`include "fps_consts.vh"

module fps_sequencer (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // debug link state
  input wire debug_mode,
  // flash-space writes (unlock bytes and page buffer data)
  input wire mem_wr,
  input wire [15:0] mem_addr,
  input wire [7:0] mem_wdata,
  // flash reads
  input wire mem_rd,
  output reg [7:0] mem_rdata,
  output reg mem_rvalid,
  // control register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [2:0] reg_sel,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // flash array side
  output reg [15:0] fl_rd_addr,
  input wire [7:0] fl_rd_data,
  output reg fl_start,
  output reg [1:0] fl_op,
  output reg fl_otp,
  output reg [19:0] fl_addr,
  output reg fl_busy,
  input wire [6:0] fl_buf_idx,
  output reg [7:0] fl_buf_data,
  // status
  output wire unlocked,
  output wire program_erase_busy_status
);

  // ==========================================================
  // state machine
  localparam ST_IDLE = 2'h0; // waiting for commands
  localparam ST_CLEAR = 2'h1; // filling the page buffer
  localparam ST_BUSY = 2'h2; // program or erase in progress

  reg [1:0] state;
  reg [1:0] next_state;

  // ==========================================================
  // control registers
  reg [7:0] flash_mode_reg;
  reg [7:0] flash_command_reg;
  reg [7:0] flash_addr_high_reg; // only low nibble used
  reg [7:0] flash_addr_mid_reg;
  reg [7:0] flash_addr_low_reg;
  reg [7:0] flash_timing_reg;
  reg done_flag; // set when an operation has completed

  // ==========================================================
  // page buffer
  reg [7:0] page_buf [0:`FPS_BUF_BYTES-1];
  reg [`FPS_BUF_AW-1:0] buf_ptr; // load pointer
  reg [`FPS_BUF_AW-1:0] clr_idx; // fill pointer while clearing

  // operation timer
  reg [7:0] unit_cnt; // cycles inside one timing unit
  reg [7:0] units_left; // whole units still to run
  reg mem_rvalid_req; // read taken last cycle

  // ==========================================================
  // qualified host actions; nothing counts outside debug mode
  wire host_ok = debug_mode;
  wire mem_wr_ok = mem_wr && host_ok;
  wire reg_wr_ok = reg_wr && host_ok;
  wire cmd_wr = reg_wr_ok && (reg_sel == `FPS_SEL_CMD);
  wire idle = (state == ST_IDLE);

  // buffer clear request: needs the reset mode and the clear command
  wire do_clear = cmd_wr && idle && unlocked
    && (flash_mode_reg == `FPS_MODE_BUF_RESET)
    && (reg_wdata == `FPS_CMD_BUF_CLEAR);

  // buffer load: data writes while buffer is selected
  wire do_load = mem_wr_ok && idle && unlocked
    && (flash_mode_reg == `FPS_MODE_BUF_SELECT);

  // page start: program or page erase, chosen by mode
  wire start_cmd = cmd_wr && idle && unlocked
    && (reg_wdata == `FPS_CMD_START);
  wire do_prog = start_cmd && (flash_mode_reg == `FPS_MODE_PROGRAM);
  wire do_perase = start_cmd && (flash_mode_reg == `FPS_MODE_ERASE);

  // bulk erase: main area, or main plus OTP
  wire bulk_cmd = cmd_wr && idle && unlocked
    && (reg_wdata == `FPS_CMD_BULK);
  wire do_bulk_main = bulk_cmd && (flash_mode_reg == `FPS_MODE_ERASE);
  wire do_bulk_otp = bulk_cmd && (flash_mode_reg == `FPS_MODE_ERASE_OTP);

  wire do_start = do_prog || do_perase || do_bulk_main || do_bulk_otp;

  // last cycle of the running operation
  wire unit_end = (unit_cnt == `FPS_UNIT_LAST);
  wire op_end = (state == ST_BUSY) && unit_end && (units_left == 8'h00);

  // ==========================================================
  // unlock checker; sees only flash-space writes in debug mode
  fps_unlock u_unlock (
    .clock(clock),
    .sys_rst(sys_rst),
    .wr(mem_wr_ok),
    .addr(mem_addr),
    .data(mem_wdata),
    .relock(!debug_mode),
    .unlocked(unlocked)
  );

  // ==========================================================
  // next state
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (do_clear) next_state = ST_CLEAR;
        else if (do_start) next_state = ST_BUSY;
      end
      ST_CLEAR: begin
        if (clr_idx == `FPS_BUF_LAST) next_state = ST_IDLE;
      end
      ST_BUSY: begin
        if (op_end) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clock) begin
    if (sys_rst) state <= ST_IDLE;
    else state <= next_state;
  end

  // ==========================================================
  // control register writes; address and timing locked while busy
  always @(posedge clock) begin
    if (sys_rst) begin
      flash_mode_reg <= `FPS_MODE_RESET_VAL;
      flash_command_reg <= `FPS_CMD_RESET_VAL;
      flash_addr_high_reg <= 8'h00;
      flash_addr_mid_reg <= 8'h00;
      flash_addr_low_reg <= 8'h00;
      flash_timing_reg <= `FPS_TIMING_RESET_VAL;
    end else if (reg_wr_ok && idle) begin
      case (reg_sel)
        `FPS_SEL_MODE: flash_mode_reg <= reg_wdata;
        `FPS_SEL_CMD: flash_command_reg <= reg_wdata;
        `FPS_SEL_ADDR_HIGH: flash_addr_high_reg <= {4'h0, reg_wdata[3:0]};
        `FPS_SEL_ADDR_MID: flash_addr_mid_reg <= reg_wdata;
        `FPS_SEL_ADDR_LOW: flash_addr_low_reg <= reg_wdata;
        `FPS_SEL_TIMING: flash_timing_reg <= reg_wdata;
        default: ; // status is read only
      endcase
    end
  end

  // ==========================================================
  // page buffer pointer and contents
  // clearing walks the whole buffer one byte a cycle; a single-cycle
  // clear would force the buffer out of memory into flops
  always @(posedge clock) begin
    if (sys_rst) begin
      buf_ptr <= 7'h00;
      clr_idx <= 7'h00;
    end else if (do_clear) begin
      buf_ptr <= 7'h00;
      clr_idx <= 7'h00;
    end else if (state == ST_CLEAR) begin
      clr_idx <= clr_idx + 7'h01;
    end else if (do_load) begin
      buf_ptr <= buf_ptr + `FPS_BUF_STEP;
    end
  end

  // buffer array write port; no reset on memory contents
  always @(posedge clock) begin
    if (state == ST_CLEAR) page_buf[clr_idx] <= `FPS_BUF_FILL;
    else if (do_load) page_buf[buf_ptr] <= mem_wdata;
  end

  // buffer read port toward the array; erase reads back the fill pattern
  always @(posedge clock) begin
    if (sys_rst) fl_buf_data <= `FPS_BUF_FILL;
    else if (fl_op == `FPS_OP_PROGRAM) fl_buf_data <= page_buf[fl_buf_idx];
    else fl_buf_data <= `FPS_BUF_FILL;
  end

  // ==========================================================
  // operation launch and timing
  always @(posedge clock) begin
    if (sys_rst) begin
      fl_start <= 1'b0;
      fl_op <= `FPS_OP_NONE;
      fl_otp <= 1'b0;
      fl_addr <= 20'h00000;
      fl_busy <= 1'b0;
      unit_cnt <= 8'h00;
      units_left <= 8'h00;
    end else begin
      fl_start <= do_start;
      if (do_start) begin
        fl_busy <= 1'b1;
        unit_cnt <= 8'h00;
        units_left <= flash_timing_reg; // timing value + 1 units
        fl_otp <= do_bulk_otp;
        if (do_prog) begin
          fl_op <= `FPS_OP_PROGRAM;
          fl_addr <= {flash_addr_high_reg[3:0], flash_addr_mid_reg,
            flash_addr_low_reg};
        end else if (do_perase) begin
          fl_op <= `FPS_OP_PAGE_ERASE;
          fl_addr <= {flash_addr_high_reg[3:0], flash_addr_mid_reg,
            flash_addr_low_reg};
        end else begin
          fl_op <= `FPS_OP_BULK_ERASE;
          fl_addr <= 20'h00000; // no page address for bulk
        end
      end else if (state == ST_BUSY) begin
        if (op_end) begin
          fl_busy <= 1'b0;
          fl_op <= `FPS_OP_NONE;
          fl_otp <= 1'b0;
        end else if (unit_end) begin
          unit_cnt <= 8'h00;
          units_left <= units_left - 8'h01;
        end else begin
          unit_cnt <= unit_cnt + 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // completion flag: set when the operation ends, cleared by a new start
  // set and clear cannot meet: a start is only taken while idle
  always @(posedge clock) begin
    if (sys_rst) done_flag <= 1'b1;
    else if (op_end) done_flag <= 1'b1;
    else if (do_start) done_flag <= 1'b0;
  end

  // host polls this until it reads 1
  assign program_erase_busy_status = done_flag;

  // ==========================================================
  // direct flash reads; no unlock or mode needed
  always @(posedge clock) begin
    if (sys_rst) begin
      fl_rd_addr <= 16'h0000;
      mem_rvalid <= 1'b0;
      mem_rdata <= 8'h00;
    end else begin
      mem_rvalid <= 1'b0;
      if (mem_rd && host_ok) fl_rd_addr <= mem_addr;
      if (mem_rvalid_req) begin
        mem_rdata <= fl_rd_data;
        mem_rvalid <= 1'b1;
      end
    end
  end

  // array answers one cycle after the address is presented
  always @(posedge clock) begin
    if (sys_rst) mem_rvalid_req <= 1'b0;
    else mem_rvalid_req <= mem_rd && host_ok;
  end

  // ==========================================================
  // register readback
  always @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && host_ok) begin
      case (reg_sel)
        `FPS_SEL_MODE: reg_rdata <= flash_mode_reg;
        `FPS_SEL_CMD: reg_rdata <= flash_command_reg;
        `FPS_SEL_ADDR_HIGH: reg_rdata <= flash_addr_high_reg;
        `FPS_SEL_ADDR_MID: reg_rdata <= flash_addr_mid_reg;
        `FPS_SEL_ADDR_LOW: reg_rdata <= flash_addr_low_reg;
        `FPS_SEL_TIMING: reg_rdata <= flash_timing_reg;
        `FPS_SEL_STATUS: begin
          reg_rdata <= 8'h00;
          reg_rdata[`FPS_STAT_READY_BIT] <= done_flag;
          reg_rdata[`FPS_STAT_UNLOCK_BIT] <= unlocked;
          reg_rdata[`FPS_STAT_CLEAR_BIT] <= (state == ST_CLEAR);
        end
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule // fps_sequencer

`default_nettype wire

// ### bench/fps_seq_asserts.sv
// port-level assertion checker for the flash program/erase sequencer
`timescale 1ns/10ps
`default_nettype none
module fps_seq_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // host side
  input wire logic debug_mode,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_rd,
  input wire logic mem_rvalid,
  input wire logic reg_wr,
  input wire logic [2:0] reg_sel,
  input wire logic [7:0] reg_wdata,
  // array side and status
  input wire logic fl_start,
  input wire logic [1:0] fl_op,
  input wire logic fl_otp,
  input wire logic [19:0] fl_addr,
  input wire logic fl_busy,
  input wire logic [7:0] fl_buf_data,
  input wire logic unlocked,
  input wire logic program_erase_busy_status
);
  // ==========================================================
  // one clock domain, reset masks everything
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // a launch must follow a start or bulk command write
  property p_start_cmd;
    fl_start |-> $past(reg_wr && reg_sel == 3'h1 && (reg_wdata == 8'h0B || reg_wdata == 8'h8B));
  endproperty
  a_start_cmd: assert property (p_start_cmd) else $error("launch without command");
  // nothing launches while locked
  property p_start_lock;
    fl_start |-> $past(unlocked);
  endproperty
  a_start_lock: assert property (p_start_lock) else $error("launch while locked");
  // launch shows busy at once, flag reads running
  property p_start_busy;
    fl_start |-> fl_busy && !program_erase_busy_status ##1 !fl_start;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("launch without busy");
  // bulk command means bulk op with zero address
  property p_bulk;
    fl_start |-> ((fl_op == 2'h3) == ($past(reg_wdata) == 8'h8B)) && (fl_op != 2'h3 || fl_addr == 20'h00000);
  endproperty
  a_bulk: assert property (p_bulk) else $error("bulk launch wrong");
  // otp area only with bulk erase
  property p_otp;
    fl_otp |-> fl_op == 2'h3;
  endproperty
  a_otp: assert property (p_otp) else $error("otp outside bulk erase");
  // erase never passes buffer content
  property p_erase_ff;
    fl_op != 2'h1 |=> fl_buf_data == 8'hFF;
  endproperty
  a_erase_ff: assert property (p_erase_ff) else $error("buffer data leaked");
  // three ordered unlock writes open the gate
  property p_unlock;
    (debug_mode && mem_wr && mem_addr == 16'hF555 && mem_wdata == 8'hAA) ##1
    (debug_mode && mem_wr && mem_addr == 16'hFAAA && mem_wdata == 8'h55) ##1
    (debug_mode && mem_wr && mem_addr == 16'hF555 && mem_wdata == 8'hA5) |=> unlocked;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock not taken");
  // leaving debug mode relocks
  property p_relock;
    !debug_mode |=> !unlocked;
  endproperty
  a_relock: assert property (p_relock) else $error("still unlocked");
  // reads answer two cycles on, no unlock needed
  property p_read;
    mem_rd && debug_mode |-> ##2 mem_rvalid;
  endproperty
  a_read: assert property (p_read) else $error("read not answered");
endmodule // fps_seq_asserts
bind fps_sequencer fps_seq_asserts fps_seq_asserts_i (.clock, .sys_rst, .debug_mode, .mem_wr,
  .mem_addr, .mem_wdata, .mem_rd, .mem_rvalid, .reg_wr, .reg_sel, .reg_wdata, .fl_start,
  .fl_op, .fl_otp, .fl_addr, .fl_busy, .fl_buf_data, .unlocked, .program_erase_busy_status);
`default_nettype wire

// ### bench/fps_flash_model.sv
// flash array stand-in: read data and page buffer sampling
`timescale 1ns/10ps
`default_nettype none
module fps_flash_model (
  // clock
  input wire logic clock,
  // from the sequencer
  input wire logic fl_busy,
  input wire logic [15:0] fl_rd_addr,
  input wire logic [7:0] fl_buf_data,
  // to the sequencer
  output logic [7:0] fl_rd_data,
  output logic [6:0] fl_buf_idx
);
  logic [7:0] got [128]; // last byte seen per buffer index
  logic [6:0] idx_q = 7'h00; // index the design sampled
  logic busy_q = 1'b0; // busy at that sample
  initial fl_buf_idx = 7'h00;
  // contents are a fixed scramble of the address
  assign fl_rd_data = fl_rd_addr[7:0] ^ {fl_rd_addr[11:8], fl_rd_addr[15:12]};
  // sweep the index every cycle so a long op sees every slot
  always @(posedge clock) begin
    fl_buf_idx <= fl_buf_idx + 7'h01;
    idx_q <= fl_buf_idx;
    busy_q <= fl_busy;
    if (busy_q) begin
      got[idx_q] <= fl_buf_data;
    end
  end
endmodule // fps_flash_model
`default_nettype wire

// ### bench/fps_sequencer_test.sv
// self-checking bench for the flash program/erase sequencer
`timescale 1ns/10ps
`default_nettype none
module fps_sequencer_test;
  logic clock = 1'b0, sys_rst = 1'b1, debug_mode = 1'b0;
  logic mem_wr = 1'b0, mem_rd = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [15:0] mem_addr = 16'h0000;
  logic [7:0] mem_wdata = 8'h00, reg_wdata = 8'h00;
  logic [2:0] reg_sel = 3'h0;
  wire logic [7:0] mem_rdata, reg_rdata, fl_rd_data, fl_buf_data;
  wire logic mem_rvalid, fl_start, fl_otp, fl_busy, unlocked, program_erase_busy_status;
  wire logic [15:0] fl_rd_addr;
  wire logic [1:0] fl_op;
  wire logic [19:0] fl_addr;
  wire logic [6:0] fl_buf_idx;
  int fails = 0, checks_done = 0, cyc = 0, seed = 20328, n;
  logic [7:0] pg [64];
  logic [7:0] v;
  logic [19:0] pa;
  logic [1:0] tm;
  fps_sequencer fps_sequencer_i (.clock, .sys_rst, .debug_mode, .mem_wr, .mem_addr,
    .mem_wdata, .mem_rd, .mem_rdata, .mem_rvalid, .reg_wr, .reg_rd, .reg_sel, .reg_wdata,
    .reg_rdata, .fl_rd_addr, .fl_rd_data, .fl_start, .fl_op, .fl_otp, .fl_addr, .fl_busy,
    .fl_buf_idx, .fl_buf_data, .unlocked, .program_erase_busy_status);
  fps_flash_model fps_flash_model_i (.clock, .fl_busy, .fl_rd_addr, .fl_buf_data,
    .fl_rd_data, .fl_buf_idx);
  initial forever #5 clock = ~clock;
  // ==========================================================
  // expectations
  function automatic logic [7:0] exp_rd(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]};
  endfunction
  function automatic int exp_dur(input logic [1:0] t);
    return (t + 1) * 100;
  endfunction
  // ==========================================================
  // drivers, all changes at the falling edge
  task automatic wrap_up;
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rw(input logic [2:0] s, input logic [7:0] d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_sel = s;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  task automatic rr(input logic [2:0] s, output logic [7:0] d);
    @(negedge clock);
    reg_rd = 1'b1;
    reg_sel = s;
    @(negedge clock);
    reg_rd = 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask
  task automatic mw(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    mem_wr = 1'b1;
    mem_addr = a;
    mem_wdata = d;
    @(negedge clock);
    mem_wr = 1'b0;
  endtask
  // three unlock writes back to back
  task automatic unlock3;
    @(negedge clock);
    mem_wr = 1'b1;
    {mem_addr, mem_wdata} = {16'hF555, 8'hAA};
    @(negedge clock);
    {mem_addr, mem_wdata} = {16'hFAAA, 8'h55};
    @(negedge clock);
    {mem_addr, mem_wdata} = {16'hF555, 8'hA5};
    @(negedge clock);
    mem_wr = 1'b0;
    @(negedge clock);
  endtask
  // clear buffer, load nb bytes, select mode m
  task automatic prep(input logic [7:0] m, input int nb);
    rw(3'h0, 8'h81);
    rw(3'h1, 8'h02);
    rr(3'h6, v);
    chk(v[2], 1'b1);
    n = 0;
    do begin
      rr(3'h6, v);
      n++;
    end while (v[2] !== 1'b0 && n < 200);
    chk(v[2], 1'b0);
    rw(3'h0, 8'h89);
    for (int i = 0; i < nb; i++) mw(i[15:0], pg[i]);
    rw(3'h0, m);
  endtask
  // launch, check launch outputs and op length
  task automatic run(input logic [7:0] c, input logic [1:0] o, input logic ot, input logic [19:0] ea);
    // page address comes from pa; a bulk launch must still show zero
    rw(3'h2, {4'h0, pa[19:16]});
    rw(3'h3, pa[15:8]);
    rw(3'h4, pa[7:0]);
    tm = 2'($random(seed)) | 2'h1;
    rw(3'h5, {6'h00, tm});
    rw(3'h1, c);
    chk({fl_start, fl_op, fl_otp, fl_addr}, {1'b1, o, ot, ea});
    n = 0;
    while (fl_busy === 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    chk(n, exp_dur(tm));
    chk(program_erase_busy_status, 1'b1);
  endtask
  // ==========================================================
  // cycle ceiling
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      wrap_up;
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    debug_mode = 1'b1;
    rr(3'h6, v);
    chk(v, 8'h01);
    for (int s = 0; s < 6; s++) begin
      rr(s[2:0], v);
      chk(v, 8'h00);
    end
    repeat (8) begin
      pa = $random(seed);
      @(negedge clock);
      mem_rd = 1'b1;
      mem_addr = pa[15:0];
      @(negedge clock);
      mem_rd = 1'b0;
      // valid pulse stands for one cycle only, two edges after the strobe
      @(negedge clock);
      chk({mem_rvalid, mem_rdata}, {1'b1, exp_rd(pa[15:0])});
    end
    rw(3'h0, 8'hA1);
    rw(3'h1, 8'h0B);
    repeat (3) @(negedge clock);
    chk({fl_busy, unlocked}, 2'b00);
    mw(16'hF555, 8'hAA);
    mw(16'hFAAA, 8'h55);
    mw(16'hF555, 8'hA4);
    mw(16'hF555, 8'hAA);
    mw(16'hF555, 8'hAA);
    chk(unlocked, 1'b0);
    mw(16'hFAAA, 8'h55);
    mw(16'hF555, 8'hA5);
    @(negedge clock);
    chk(unlocked, 1'b1);
    debug_mode = 1'b0;
    repeat (2) @(negedge clock);
    debug_mode = 1'b1;
    chk(unlocked, 1'b0);
    unlock3;
    // two pages programmed with random data
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 64; i++) pg[i] = $random(seed);
      prep(8'hA1, 64);
      pa = $random(seed);
      run(8'h0B, 2'h1, 1'b0, pa);
      for (int i = 0; i < 64; i++) begin
        chk(fps_flash_model_i.got[2 * i], pg[i]);
        chk(fps_flash_model_i.got[2 * i + 1], 8'hFF);
      end
    end
    // page erase ignores the loaded byte, repeated for two pages
    for (int k = 0; k < 2; k++) begin
      pg[0] = 8'h00;
      prep(8'h91, 1);
      pa = $random(seed);
      run(8'h0B, 2'h2, 1'b0, pa);
      for (int i = 0; i < 128; i++) chk(fps_flash_model_i.got[i], 8'hFF);
    end
    // bulk erase, main area then with otp
    prep(8'h91, 1);
    run(8'h8B, 2'h3, 1'b0, 20'h00000);
    prep(8'h8D, 1);
    run(8'h8B, 2'h3, 1'b1, 20'h00000);
    wrap_up;
  end
endmodule // fps_sequencer_test
`default_nettype wire
